// ==== dcmui_mapper.sv ====
// Front-panel channel mapper: key/encoder modes, working map, three stored
// maps, test overrides and the radio level stream, with an APB slave.
// Assumes key and encoder inputs are one-cycle pulses synchronous to clk_i.
// Function
// - Encoder in monitor steps through 512 DMX plus 8 analog, 520 sources.
// - Monitor dec/inc keys move ten DMX channels, skipping analog inputs.
// - Analog inputs sit after DMX 512 and before DMX 1 in order.
// - Block start mode entered from monitor preloads start with monitored DMX channel.
// - Confirmed block start maps consecutive DMX channels to radio channels.
// - Block starts above 480 wrap around to DMX channel 0.
// - Block assign never maps analog; overwrites working map only.
// - Single edit gives each radio channel one source; new replaces old.
// - Two-parameter edit: keys step radio channel, encoder steps source.
// - Edited values take effect only on enter or encoder push.
// - Three stored map slots; save overwrites slot, returns to monitor.
// - Recall replaces whole working map with stored slot contents.
// - After reset load stored map, enter monitor, start transmitting.
// - Test modes keep normal sending; only tested channel is overridden.
// - Manual test steps 25, 5, 1; encoder push cycles step size.
// - Manual level spans 0 to 255; dec/inc keys pick radio channel.
// - Enter in manual test toggles chase flag of shown channel.
// - Chase ramps each flagged channel 0 to 255 to 0, then next.
// - Encoder sets chase speed: 3-4 s fade slowest, 4 per second fastest.
// - Manual and chase test keys switch directly between those modes.
// - Exit aborts any function except a running map copy and returns to monitor.
// - All 32 radio levels are sent repeatedly about 60 times a second.
`timescale 1ns/10ps
`default_nettype none
module dcmui_mapper #(
  parameter int FRAME_CYC = dcmui_pkg::FRAME_CYC,
  parameter int CHASE_CYC = dcmui_pkg::CHASE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire dcmui_pkg::dcmui_keys_type keys_i,
  input wire dcmui_pkg::dcmui_srcwr_type src_wr_i,
  output dcmui_pkg::dcmui_tx_type tx_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output dcmui_pkg::dcmui_disp_type disp_o
);
  dcmui_pkg::dcmui_mode_type mode_r;
  dcmui_pkg::dcmui_res_type res_r;
  dcmui_pkg::dcmui_map_type map_r [dcmui_pkg::N_RCH];
  dcmui_pkg::dcmui_map_type nv_r [dcmui_pkg::N_SLOT][dcmui_pkg::N_RCH];
  logic [7:0] lvl_mem [dcmui_pkg::N_SRC];
  logic [9:0] disp_src_r, edit_src_r;
  logic [8:0] blk_start_r;
  logic [4:0] edit_rch_r, test_ch_r, chase_ch_r, cnt_r, tx_ch_r;
  logic [1:0] slot_r;
  logic [7:0] man_lvl_r, chase_lvl_r, step;
  logic [3:0] chase_spd_r;
  logic chase_up_r, tx_en_r, tx_ovr_r, tx_asg_r;
  logic [31:0] flags_r;
  logic frame_tick, chase_tick, enc_any, confirm;
  // Nothing is imported, so the package codes get local names here
  localparam dcmui_pkg::dcmui_mode_type M_LOAD = dcmui_pkg::M_LOAD;
  localparam dcmui_pkg::dcmui_mode_type M_MON = dcmui_pkg::M_MON;
  localparam dcmui_pkg::dcmui_mode_type M_BLOCK = dcmui_pkg::M_BLOCK;
  localparam dcmui_pkg::dcmui_mode_type M_EDIT = dcmui_pkg::M_EDIT;
  localparam dcmui_pkg::dcmui_mode_type M_SAVE = dcmui_pkg::M_SAVE;
  localparam dcmui_pkg::dcmui_mode_type M_RECALL = dcmui_pkg::M_RECALL;
  localparam dcmui_pkg::dcmui_mode_type M_COPY_S = dcmui_pkg::M_COPY_S;
  localparam dcmui_pkg::dcmui_mode_type M_COPY_R = dcmui_pkg::M_COPY_R;
  localparam dcmui_pkg::dcmui_mode_type M_MTEST = dcmui_pkg::M_MTEST;
  localparam dcmui_pkg::dcmui_mode_type M_CHASE = dcmui_pkg::M_CHASE;
  localparam dcmui_pkg::dcmui_res_type R_COARSE = dcmui_pkg::R_COARSE;
  localparam dcmui_pkg::dcmui_res_type R_MEDIUM = dcmui_pkg::R_MEDIUM;
  localparam dcmui_pkg::dcmui_res_type R_FINE = dcmui_pkg::R_FINE;

  assign enc_any = keys_i.enc_cw | keys_i.enc_ccw;
  assign confirm = keys_i.enter_k | keys_i.push_k;

  dcmui_tick #(.PERIOD(FRAME_CYC)) u_frame (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_o(frame_tick));
  dcmui_tick #(.PERIOD(CHASE_CYC)) u_chase (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_o(chase_tick));

  // Source order DMX 1..512, then analog 1..8, then back to DMX 1
  function automatic logic [9:0] src_step(logic [9:0] s, logic up);
    if (up) begin
      return (s == dcmui_pkg::SRC_LAST) ? 10'h000 : s + 10'h001;
    end
    return (s == 10'h000) ? dcmui_pkg::SRC_LAST : s - 10'h001;
  endfunction

  function automatic logic [4:0] next_flag(logic [4:0] cur,
                                           logic [31:0] fl);
    logic [4:0] idx;
    logic [4:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= dcmui_pkg::N_RCH; i++) begin
      idx = 5'(int'(cur) + i);
      if (!found && fl[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  always_comb begin
    unique case (res_r)
      R_COARSE: step = dcmui_pkg::STEP_C;
      R_MEDIUM: step = dcmui_pkg::STEP_M;
      default: step = dcmui_pkg::STEP_F;
    endcase
  end

  // Input level store for the 520 sources
  always_ff @(posedge clk_i) begin
    if (src_wr_i.valid && src_wr_i.idx <= dcmui_pkg::SRC_LAST) begin
      lvl_mem[src_wr_i.idx] <= src_wr_i.level;
    end
  end

  // Mode sequencing
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_r <= M_LOAD;
      cnt_r <= '0;
    end else if (mode_r == M_LOAD || mode_r == M_COPY_S ||
                 mode_r == M_COPY_R) begin
      // Copies run to completion so a map is never left half written
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == dcmui_pkg::RCH_LAST) begin
        mode_r <= M_MON;
      end
    end else if (keys_i.exit_k) begin
      mode_r <= M_MON;
    end else if (keys_i.block_k) begin
      mode_r <= M_BLOCK;
    end else if (keys_i.edit_k) begin
      mode_r <= M_EDIT;
    end else if (keys_i.save_k) begin
      mode_r <= M_SAVE;
    end else if (keys_i.recall_k) begin
      mode_r <= M_RECALL;
    end else if (keys_i.mtest_k) begin
      mode_r <= M_MTEST;
    end else if (keys_i.chase_k) begin
      mode_r <= M_CHASE;
    end else if (confirm) begin
      cnt_r <= '0;
      unique case (mode_r)
        M_BLOCK: mode_r <= M_MON;
        M_SAVE: mode_r <= M_COPY_S;
        M_RECALL: mode_r <= M_COPY_R;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Working map and stored maps
  always_ff @(posedge clk_i) begin
    if (mode_r == M_LOAD) begin
      map_r[cnt_r] <= nv_r[dcmui_pkg::BOOT_SLOT][cnt_r];
    end else if (mode_r == M_COPY_R) begin
      map_r[cnt_r] <= nv_r[slot_r][cnt_r];
    end else if (mode_r == M_COPY_S) begin
      nv_r[slot_r][cnt_r] <= map_r[cnt_r];
    end else if (confirm && !keys_i.exit_k && mode_r == M_BLOCK) begin
      for (int k = 0; k < dcmui_pkg::N_RCH; k++) begin
        // 9-bit sum wraps past DMX 512 to channel 0; never analog
        map_r[k] <= '{1'b1, {1'b0, 9'(blk_start_r + 9'(k))}};
      end
    end else if (confirm && !keys_i.exit_k && mode_r == M_EDIT) begin
      map_r[edit_rch_r] <= '{1'b1, edit_src_r};
    end
  end

  // Monitor position and block start
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      disp_src_r <= '0;
      blk_start_r <= '0;
    end else if (mode_r == M_MON) begin
      if (keys_i.block_k) begin
        blk_start_r <= disp_src_r[9] ? 9'h000 : disp_src_r[8:0];
      end
      if (enc_any) begin
        disp_src_r <= src_step(disp_src_r, keys_i.enc_cw);
      end else if (keys_i.inc_k) begin
        disp_src_r <= disp_src_r[9] ? 10'h000 :
          {1'b0, 9'(disp_src_r[8:0] + 9'(dcmui_pkg::MON_JUMP))};
      end else if (keys_i.dec_k) begin
        disp_src_r <= disp_src_r[9] ? dcmui_pkg::DMX_LAST :
          {1'b0, 9'(disp_src_r[8:0] - 9'(dcmui_pkg::MON_JUMP))};
      end
    end else if (mode_r == M_BLOCK && enc_any) begin
      blk_start_r <= keys_i.enc_cw ? blk_start_r + 9'h001 :
                                     blk_start_r - 9'h001;
    end
  end

  // Single edit and slot choice
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      edit_src_r <= '0;
      edit_rch_r <= '0;
      slot_r <= '0;
    end else if (mode_r == M_EDIT) begin
      if (enc_any) begin
        edit_src_r <= src_step(edit_src_r, keys_i.enc_cw);
      end
      if (keys_i.inc_k) begin
        edit_rch_r <= edit_rch_r + 5'h01;
      end else if (keys_i.dec_k) begin
        edit_rch_r <= edit_rch_r - 5'h01;
      end
    end else if ((mode_r == M_SAVE || mode_r == M_RECALL) && enc_any) begin
      if (keys_i.enc_cw) begin
        slot_r <= (slot_r == dcmui_pkg::SLOT_LAST) ? 2'h0 : slot_r + 2'h1;
      end else begin
        slot_r <= (slot_r == 2'h0) ? dcmui_pkg::SLOT_LAST : slot_r - 2'h1;
      end
    end
  end

  // Manual test
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      test_ch_r <= '0;
      man_lvl_r <= '0;
      res_r <= R_COARSE;
      flags_r <= '0;
    end else if (mode_r == M_MTEST) begin
      if (keys_i.inc_k) begin
        test_ch_r <= test_ch_r + 5'h01;
      end else if (keys_i.dec_k) begin
        test_ch_r <= test_ch_r - 5'h01;
      end
      if (keys_i.enc_cw) begin
        man_lvl_r <= (man_lvl_r > dcmui_pkg::LVL_MAX - step) ?
                     dcmui_pkg::LVL_MAX : man_lvl_r + step;
      end else if (keys_i.enc_ccw) begin
        man_lvl_r <= (man_lvl_r < step) ? 8'h00 : man_lvl_r - step;
      end
      if (keys_i.push_k) begin
        unique case (res_r)
          R_COARSE: res_r <= R_MEDIUM;
          R_MEDIUM: res_r <= R_FINE;
          default: res_r <= R_COARSE;
        endcase
      end
      if (keys_i.enter_k) begin
        flags_r[test_ch_r] <= ~flags_r[test_ch_r];
      end
    end
  end

  // Chase: speed is the level step taken at each chase tick
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chase_spd_r <= dcmui_pkg::SPD_MIN;
      chase_ch_r <= '0;
      chase_lvl_r <= '0;
      chase_up_r <= 1'b1;
    end else if (mode_r != M_CHASE) begin
      chase_ch_r <= next_flag(dcmui_pkg::RCH_LAST, flags_r);
      chase_lvl_r <= '0;
      chase_up_r <= 1'b1;
    end else begin
      if (keys_i.enc_cw && chase_spd_r != dcmui_pkg::SPD_MAX) begin
        chase_spd_r <= chase_spd_r + 4'h1;
      end else if (keys_i.enc_ccw && chase_spd_r != dcmui_pkg::SPD_MIN) begin
        chase_spd_r <= chase_spd_r - 4'h1;
      end
      if (chase_tick && flags_r != '0) begin
        if (chase_up_r) begin
          if (chase_lvl_r > dcmui_pkg::LVL_MAX - 8'(chase_spd_r)) begin
            chase_lvl_r <= dcmui_pkg::LVL_MAX;
            chase_up_r <= 1'b0;
          end else begin
            chase_lvl_r <= chase_lvl_r + 8'(chase_spd_r);
          end
        end else if (chase_lvl_r <= 8'(chase_spd_r)) begin
          chase_lvl_r <= '0;
          chase_up_r <= 1'b1;
          chase_ch_r <= next_flag(chase_ch_r, flags_r);
        end else begin
          chase_lvl_r <= chase_lvl_r - 8'(chase_spd_r);
        end
      end
    end
  end

  // Radio stream: one word per channel, 32 words per frame
  logic tx_start, tx_adv, n_ovr;
  logic [4:0] n_ch;
  logic [7:0] n_lvl;
  assign tx_start = frame_tick && tx_en_r && !tx_valid_o;
  assign tx_adv = tx_valid_o && tx_ready_i &&
                  tx_ch_r != dcmui_pkg::RCH_LAST;
  assign n_ch = tx_start ? 5'h00 : tx_ch_r + 5'h01;

  always_comb begin
    n_ovr = 1'b0;
    n_lvl = map_r[n_ch].used ? lvl_mem[map_r[n_ch].src] : 8'h00;
    if (mode_r == M_MTEST && n_ch == test_ch_r) begin
      n_ovr = 1'b1;
      n_lvl = man_lvl_r;
    end else if (mode_r == M_CHASE && flags_r != '0 &&
                 n_ch == chase_ch_r) begin
      n_ovr = 1'b1;
      n_lvl = chase_lvl_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_valid_o <= 1'b0;
      tx_ch_r <= '0;
      tx_o <= '0;
      tx_ovr_r <= 1'b0;
      tx_asg_r <= 1'b0;
    end else if (tx_start || tx_adv) begin
      tx_valid_o <= 1'b1;
      tx_ch_r <= n_ch;
      tx_o <= '{n_ch, n_lvl};
      tx_ovr_r <= n_ovr;
      tx_asg_r <= map_r[n_ch].used;
    end else if (tx_valid_o && tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // Display snapshot
  logic mon_asg;
  logic [4:0] mon_rch;
  always_comb begin
    mon_asg = 1'b0;
    mon_rch = '0;
    for (int k = dcmui_pkg::N_RCH - 1; k >= 0; k--) begin
      if (map_r[k].used && map_r[k].src == disp_src_r) begin
        mon_asg = 1'b1;
        mon_rch = 5'(k);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      disp_o <= '0;
    end else begin
      disp_o.mode <= mode_r;
      disp_o.res <= res_r;
      disp_o.slot <= slot_r;
      disp_o.chase_yes <= flags_r[test_ch_r];
      unique case (mode_r)
        M_EDIT: begin
          disp_o.src <= edit_src_r;
          disp_o.rch <= edit_rch_r;
          disp_o.asg <= map_r[edit_rch_r].used;
          disp_o.level <= lvl_mem[edit_src_r];
        end
        M_BLOCK: begin
          disp_o.src <= {1'b0, blk_start_r};
          disp_o.rch <= '0;
          disp_o.asg <= 1'b0;
          disp_o.level <= lvl_mem[{1'b0, blk_start_r}];
        end
        M_MTEST, M_CHASE: begin
          disp_o.src <= map_r[test_ch_r].src;
          disp_o.rch <= (mode_r == M_MTEST) ? test_ch_r : chase_ch_r;
          disp_o.asg <= map_r[test_ch_r].used;
          disp_o.level <= (mode_r == M_MTEST) ? man_lvl_r : chase_lvl_r;
        end
        default: begin
          disp_o.src <= disp_src_r;
          disp_o.rch <= mon_rch;
          disp_o.asg <= mon_asg;
          disp_o.level <= lvl_mem[disp_src_r];
        end
      endcase
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  logic apb_hit;
  assign apb_hit = paddr_i == dcmui_pkg::REG_CTRL ||
                   paddr_i == dcmui_pkg::REG_STATUS ||
                   paddr_i == dcmui_pkg::REG_CHASE;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
      tx_en_r <= dcmui_pkg::CTRL_TXEN_RST;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !apb_hit;
      prdata_o <= '0;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        unique case (paddr_i)
          dcmui_pkg::REG_CTRL: prdata_o[dcmui_pkg::CTRL_TXEN] <= tx_en_r;
          dcmui_pkg::REG_STATUS: begin
            prdata_o[dcmui_pkg::ST_MODE_LSB +: 4] <= mode_r;
            prdata_o[dcmui_pkg::ST_SRC_LSB +: 10] <= disp_src_r;
          end
          dcmui_pkg::REG_CHASE: prdata_o <= flags_r;
          default: prdata_o <= '0;
        endcase
      end
      if (psel_i && penable_i && !pready_o && pwrite_i &&
          paddr_i == dcmui_pkg::REG_CTRL) begin
        tx_en_r <= pwdata_i[dcmui_pkg::CTRL_TXEN];
      end
    end
  end

  a_exit_to_mon: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    keys_i.exit_k && mode_r != M_LOAD && mode_r != M_COPY_S &&
    mode_r != M_COPY_R |=> mode_r == M_MON) else $error("exit not honoured");
  a_save_returns: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_COPY_S && cnt_r == dcmui_pkg::RCH_LAST |=> mode_r == M_MON)
    else $error("save did not return to monitor");
  a_src_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_MON && keys_i.enc_cw && disp_src_r == dcmui_pkg::SRC_LAST
    |=> disp_src_r == 10'h000) else $error("source order wrap wrong");
  a_mon_jump: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_MON && !enc_any && keys_i.inc_k && disp_src_r < 10'h1f6
    |=> disp_src_r == $past(disp_src_r) + 10'h00a) else $error("jump wrong");
  a_block_preload: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_MON && keys_i.block_k && !keys_i.exit_k && !disp_src_r[9]
    |=> mode_r == M_BLOCK ##0 blk_start_r == $past(disp_src_r[8:0]))
    else $error("block start not preloaded");
  a_block_fill: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_BLOCK && confirm && !keys_i.exit_k && !keys_i.block_k &&
    !keys_i.edit_k && !keys_i.save_k && !keys_i.recall_k &&
    !keys_i.mtest_k && !keys_i.chase_k
    |=> map_r[0].src == {1'b0, $past(blk_start_r)} &&
        map_r[31].src == {1'b0, 9'($past(blk_start_r) + 9'h01f)} &&
        map_r[31].used && mode_r == M_MON) else $error("block map wrong");
  a_edit_replace: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_EDIT && confirm && !keys_i.exit_k
    |=> map_r[$past(edit_rch_r)] == {1'b1, $past(edit_src_r)})
    else $error("edit not stored");
  a_res_cycle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_r == M_MTEST && keys_i.push_k && res_r == R_FINE && !keys_i.exit_k
    |=> res_r == R_COARSE) else $error("resolution cycle wrong");
  a_tx_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_valid_o && !tx_asg_r && !tx_ovr_r |-> tx_o.level == 8'h00)
    else $error("unassigned channel sent nonzero");
  a_tx_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
    else $error("radio word dropped before accept");
endmodule
`default_nettype wire

// ==== dcmui_pkg.sv ====
// Shared constants and carriers for the channel mapper front panel.
// Assumes a single 50 MHz clock; all users refer to names via dcmui_pkg::.
package dcmui_pkg;
  localparam int CLK_NS = 20;
  localparam int N_DMX = 512;
  localparam int N_CV = 8;
  localparam int N_SRC = N_DMX + N_CV;
  localparam int N_RCH = 32;
  localparam int N_SLOT = 3;
  localparam int MON_JUMP = 10;
  localparam logic [9:0] SRC_LAST = 10'h207;
  localparam logic [9:0] DMX_LAST = 10'h1ff;
  localparam logic [4:0] RCH_LAST = 5'h1f;
  localparam logic [1:0] SLOT_LAST = 2'h2;
  localparam logic [1:0] BOOT_SLOT = 2'h0;
  localparam logic [7:0] LVL_MAX = 8'hff;
  localparam logic [7:0] STEP_C = 8'h19;
  localparam logic [7:0] STEP_M = 8'h05;
  localparam logic [7:0] STEP_F = 8'h01;
  localparam logic [3:0] SPD_MIN = 4'h1;
  localparam logic [3:0] SPD_MAX = 4'he;
  // Radio refresh near 60 per second
  localparam int FRAME_NS = 16_667_000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  // Chase step interval; 510 unit steps give about 3.5 s at slowest speed
  localparam int CHASE_NS = 6_860_000;
  localparam int CHASE_CYC = CHASE_NS / CLK_NS;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHASE = 8'h08;
  localparam int CTRL_TXEN = 0;
  localparam logic CTRL_TXEN_RST = 1'b1;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_SRC_LSB = 16;

  typedef enum logic [3:0] {
    M_LOAD, M_MON, M_BLOCK, M_EDIT, M_SAVE, M_RECALL, M_COPY_S, M_COPY_R,
    M_MTEST, M_CHASE
  } dcmui_mode_type;

  typedef enum logic [1:0] {R_COARSE, R_MEDIUM, R_FINE} dcmui_res_type;

  typedef struct packed {
    logic exit_k;
    logic block_k;
    logic edit_k;
    logic save_k;
    logic recall_k;
    logic mtest_k;
    logic chase_k;
    logic dec_k;
    logic inc_k;
    logic enter_k;
    logic push_k;
    logic enc_cw;
    logic enc_ccw;
  } dcmui_keys_type;

  typedef struct packed {
    logic used;
    logic [9:0] src;
  } dcmui_map_type;

  typedef struct packed {
    logic valid;
    logic [9:0] idx;
    logic [7:0] level;
  } dcmui_srcwr_type;

  typedef struct packed {
    logic [4:0] chan;
    logic [7:0] level;
  } dcmui_tx_type;

  typedef struct packed {
    dcmui_mode_type mode;
    logic [9:0] src;
    logic [7:0] level;
    logic [4:0] rch;
    logic asg;
    dcmui_res_type res;
    logic chase_yes;
    logic [1:0] slot;
  } dcmui_disp_type;
endpackage

// ==== dcmui_radio.sv ====
// Radio side model: takes level words, stalls one cycle in three.
// Assumes the mapper's valid/ready word handshake on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dcmui_radio (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire dcmui_pkg::dcmui_tx_type tx_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [31:0][7:0] lv_o,
  output logic [15:0] frames_o,
  output logic bad_o
);
  logic [1:0] cnt_r;
  logic [4:0] exp_r;
  // Slow acceptance proves each word is held until taken
  assign ready_o = cnt_r != 2'h0;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || cnt_r == 2'h2) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exp_r <= 5'h0;
      frames_o <= 16'h0;
      bad_o <= 1'b0;
    end else if (valid_i && ready_o) begin
      lv_o[tx_i.chan] <= tx_i.level;
      bad_o <= bad_o | (tx_i.chan != exp_r);
      exp_r <= exp_r + 5'h1;
      if (tx_i.chan == 5'h1f) begin
        frames_o <= frames_o + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dcmui_tick.sv ====
// Free-running divider giving a one-cycle enable every PERIOD clocks.
// Assumes a synchronous active-low reset in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module dcmui_tick #(
  parameter int PERIOD = 1000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb_dcmui_mapper.sv ====
// Testbench for the channel mapper: keys, APB and radio frames.
// Assumes dcmui_radio as the far side and short frame timing.
`timescale 1ns/10ps
`default_nettype none
module tb_dcmui_mapper;
  logic clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic rdy, valid, bad, e, f;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0][7:0] lv;
  logic [15:0] frames;
  logic [1:0] s;
  logic [4:0] c;
  dcmui_pkg::dcmui_keys_type keys;
  dcmui_pkg::dcmui_srcwr_type srcwr;
  dcmui_pkg::dcmui_tx_type tx;
  dcmui_pkg::dcmui_disp_type disp;
  int num_errors, samples_checked, mon;
  int ks[7] = '{1, 2, 1, 2, 1, 2, 1};
  int ex[7] = '{25, 25, 30, 30, 31, 31, 56};
  dcmui_mapper #(.FRAME_CYC(100), .CHASE_CYC(4)) i_dcmui_mapper (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .keys_i(keys), .src_wr_i(srcwr), .tx_o(tx),
    .tx_valid_o(valid), .tx_ready_i(rdy), .disp_o(disp));
  dcmui_radio i_dcmui_radio (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tx_i(tx), .valid_i(valid), .ready_o(rdy), .lv_o(lv),
    .frames_o(frames), .bad_o(bad));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [7:0] lvl(int i);
    return 8'(i * 3 + 1);
  endfunction
  // Expected monitor position after one key: 1 cw, 0 ccw, 4 inc, 5 dec
  function automatic int step(int m, int b);
    case (b)
      1: return (m + 1) % 520;
      0: return (m + 519) % 520;
      4: return m > 511 ? 0 : (m + 10) % 512;
      default: return m > 511 ? 511 : (m + 502) % 512;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    chk(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic key(input int b);
    @(posedge clk_i);
    keys <= dcmui_pkg::dcmui_keys_type'(13'h1 << b);
    @(posedge clk_i);
    keys <= '0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic mkey(input int b);
    key(b);
    mon = step(mon, b);
    apb(1'b0, 8'h04);
    chk({22'h0, r[25:16]}, 32'(mon));
  endtask
  task automatic setlv(input int i);
    @(posedge clk_i);
    srcwr <= '{1'b1, 10'(i), lvl(i)};
    @(posedge clk_i);
    srcwr <= '0;
  endtask
  task automatic fchk(input int st, input int oc, input logic [7:0] ol);
    int n;
    int k;
    n = frames;
    k = 0;
    while (frames < n + 2 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(k < 2000), 32'h1);
    for (int i = 0; i < 32; i++) begin
      chk({24'h0, lv[i]}, {24'h0, i == oc ? ol : lvl((st + i) % 512)});
    end
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {reset_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
    keys = '0;
    srcwr = '0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(32'(disp.mode), 32'(dcmui_pkg::M_MON));
    apb(1'b0, 8'h00);
    chk(r, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00);
    chk(r, 32'h0);
    repeat (100) @(posedge clk_i);
    mon = int'(frames);
    repeat (300) @(posedge clk_i);
    chk(32'(frames), 32'(mon));
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h0c);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h04);
    mon = int'(r[25:16]);
    mkey(4);
    while (mon != 0) mkey(0);
    mkey(0);
    mkey(5);
    mkey(1);
    mkey(4);
    mkey(5);
    $display("done: monitor");
    for (int i = 0; i < 32; i++) begin
      setlv((502 + i) % 512);
      setlv(i);
    end
    key(11);
    key(3);
    fchk(502, 99, 8'h0);
    chk(32'({disp.asg, disp.rch}), 32'h20);
    key(9);
    s = disp.slot;
    key(3);
    repeat (40) @(posedge clk_i);
    chk(32'(disp.mode), 32'(dcmui_pkg::M_MON));
    mkey(4);
    key(11);
    key(3);
    fchk(0, 99, 8'h0);
    key(8);
    for (int j = 0; j < 3 && disp.slot !== s; j++) key(1);
    key(3);
    repeat (40) @(posedge clk_i);
    fchk(502, 99, 8'h0);
    $display("done: maps");
    key(7);
    repeat (11) key(0);
    chk({24'h0, disp.level}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      key(ks[i]);
      chk({24'h0, disp.level}, 32'(ex[i]));
    end
    c = disp.rch;
    fchk(502, int'(c), 8'h38);
    repeat (8) key(1);
    chk({24'h0, disp.level}, 32'hff);
    f = disp.chase_yes;
    key(3);
    chk(32'(disp.chase_yes), 32'(!f));
    apb(1'b0, 8'h08);
    chk(32'(r[c]), 32'(!f));
    key(4);
    chk(32'(disp.rch), 32'(c + 5'h1));
    key(6);
    chk(32'(disp.mode), 32'(dcmui_pkg::M_CHASE));
    repeat (13) key(1);
    // At the fastest speed the ramp reaches full level within this span
    e = 1'b0;
    repeat (300) begin
      @(posedge clk_i);
      if (disp.level == 8'hff) e = 1'b1;
    end
    chk(32'(e), 32'h1);
    key(7);
    chk(32'(disp.mode), 32'(dcmui_pkg::M_MTEST));
    key(10);
    key(1);
    key(4);
    key(3);
    fchk(502, 1, 8'h04);
    key(12);
    chk(32'(disp.mode), 32'(dcmui_pkg::M_MON));
    chk(32'(bad), 32'h0);
    $display("done: tests");
    report_and_stop();
  end
endmodule
`default_nettype wire
